// File: shared/cfg_loader_pkg.sv
// Constants, types and register map of the configuration auto-loader.
// Assumes a 10 MHz pclk and a 16-bit-word serial memory.
package cfg_loader_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SK_HALF_NS = 400;
    localparam int SK_HALF_CYCLES = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Serial memory framing
    localparam int CMD_BITS = 9;
    localparam int DATA_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
    localparam logic [2:0] READ_CMD = 3'h6;

    // ==========================================================
    // Configuration word layout
    localparam logic [5:0] WORD_SIG = 6'h00;
    localparam logic [5:0] WORD_COUNT = 6'h01;
    localparam logic [5:0] WORD_SETUP = 6'h02;
    localparam logic [5:0] WORD_MAC0 = 6'h03;
    localparam logic [5:0] WORD_LAST = 6'h05;
    localparam logic [15:0] SIGNATURE = 16'h5AA5;
    localparam int PHY_FIELD_LSB = 8;
    localparam int IRQ_TYPE_BIT = 5;
    localparam int IRQ_POL_BIT = 4;
    localparam int FILL_SEL_BIT = 2;
    localparam logic [7:0] FILL_SET = 8'h57;
    localparam logic [7:0] FILL_CLR = 8'h42;

    // PHY mode codes
    localparam logic [2:0] PHY_AN_ALL = 3'h0;
    localparam logic [2:0] PHY_AN_100 = 3'h1;
    localparam logic [2:0] PHY_AN_10 = 3'h2;
    localparam logic [2:0] PHY_RSVD = 3'h3;
    localparam logic [2:0] PHY_F100_FD = 3'h4;
    localparam logic [2:0] PHY_F100_HD = 3'h5;
    localparam logic [2:0] PHY_F10_FD = 3'h6;
    localparam logic [2:0] PHY_F10_HD = 3'h7;

    // ==========================================================
    // SRAM target regions
    localparam logic [15:0] SRAM_LO_BASE = 16'h0000;
    localparam logic [15:0] SRAM_HI_BASE = 16'h0400;
    localparam logic [4:0] LO_ENTRIES = 5'h10;
    localparam logic [4:0] COPY_LAST = 5'h17;
    localparam logic [4:0] MAC_BYTES = 5'h06;
    localparam logic [4:0] FILL_FIRST = 5'h0E;
    localparam logic [4:0] HI_FILL = 5'h07;

    // ==========================================================
    // APB register map (byte addresses)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_PHY = 8'h04;
    localparam logic [7:0] REG_MAC_LO = 8'h08;
    localparam logic [7:0] REG_MAC_HI = 8'h0C;
    localparam logic [7:0] REG_BUS_TYPE = 8'h10;
    localparam logic [7:0] REG_MEM_PORT = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;
    localparam logic [7:0] BUS_TYPE_CONTROL_REG_RESET = 8'h00;
    localparam int PORT_START_BIT = 31;
    localparam int PORT_REFUSED_BIT = 30;

    // ==========================================================
    // Types
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_READ = 6'b000010,
        ST_WAIT = 6'b000100,
        ST_NEXT = 6'b001000,
        ST_COPY = 6'b010000,
        ST_DONE = 6'b100000
    } load_state_t;

    typedef struct packed {
        logic autoneg;
        logic adv_100_full;
        logic adv_100_half;
        logic adv_10_full;
        logic adv_10_half;
        logic force_100;
        logic force_full;
    } phy_cfg_t;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } sram_wr_t;

    typedef struct packed {
        logic select;
        logic clock;
        logic data_out;
        logic data_oe;
    } cfgmem_pins_t;

endpackage

// File: src/pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to pclk; only stage two is read outside.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else if (ce)
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pin_sync
`default_nettype wire

// File: src/cfgmem_reader.sv
// Serial configuration memory reader: start bit, read opcode, six address
// bits, then sixteen data bits. Assumes data_in is already synchronised.
`timescale 1ns/10ps
`default_nettype none
module cfgmem_reader
    import cfg_loader_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [5:0] word_addr,
    input wire logic data_in,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output cfgmem_pins_t pins
);
    logic [FRAME_BITS-1:0] shift;
    logic [4:0] bit_cnt;
    logic [7:0] div_cnt;
    logic half_end;

    assign half_end = (div_cnt == 8'(SK_HALF_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            shift <= '0;
            bit_cnt <= '0;
            div_cnt <= '0;
            rdata <= '0;
            pins <= '0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (!busy)
            begin
                if (start)
                begin
                    busy <= 1'b1;
                    shift <= {READ_CMD, word_addr, 16'h0000};
                    bit_cnt <= '0;
                    div_cnt <= '0;
                    pins <= '{select: 1'b1, clock: 1'b0, data_out: READ_CMD[2],
                              data_oe: 1'b1};
                end
            end
            else if (!half_end)
                div_cnt <= div_cnt + 8'h01;
            else
            begin
                div_cnt <= '0;
                if (!pins.clock)
                begin
                    // Rising edge: sample only once the command is out
                    pins.clock <= 1'b1;
                    if (bit_cnt >= 5'(CMD_BITS))
                        rdata <= {rdata[14:0], data_in};
                end
                else
                begin
                    pins.clock <= 1'b0;
                    if (bit_cnt == 5'(FRAME_BITS - 1))
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        pins <= '0;
                    end
                    else
                    begin
                        bit_cnt <= bit_cnt + 5'h01;
                        shift <= {shift[FRAME_BITS-2:0], 1'b0};
                        pins.data_out <= shift[FRAME_BITS-2];
                        // Release the line before the memory drives data
                        pins.data_oe <= (bit_cnt < 5'(CMD_BITS - 1));
                    end
                end
            end
        end
    end
endmodule // cfgmem_reader
`default_nettype wire

// File: src/cfg_autoloader.sv
// Power-on configuration loader with APB command/status registers.
// Assumes a serial memory on the cfgmem pins and an SRAM write port outside.
//
// Notes on behaviour
// - Loader idles while hardware reset pin is low; loads on its release.
// - A hardware reset with a valid signature copies memory into SRAM 0000h-001Fh and 0400h-040Fh.
// - Loader writes SRAM only, never the station address registers; here REG_MAC_LO and REG_MAC_HI read back the loaded words 3-5.
// - Word 0 must equal 5AA5h to mark the memory valid.
// - Bad signature means no memory; PHY stays auto-negotiating all abilities.
// - Host memory port at offset 14h works only after loading completes.
// - Words 3,4,5 hold station address bytes, low byte first.
// - Word 2 bits 10:8 pick PHY auto-negotiation modes 000,001,010.
// - Code 100 forces 100 Mb/s full duplex, no auto-negotiation.
// - Test clock select switches main clock source to the test clock.
// - Codes 101,110,111 force 100 half, 10 full, 10 half.
// - Word 1 gives total words transferred during the load.
// - Loaded irq type and polarity OR into bus type control until written.
// - Word 2 bit 2 fills SRAM 1Ch-1Fh with 57h, else 42h.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module cfg_autoloader
    import cfg_loader_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_reset_n,
    input wire logic test_clock_select,
    input wire logic test_mode_sel_a,
    input wire logic test_mode_sel_b,
    input wire logic cfgmem_data_in,
    output cfgmem_pins_t cfgmem_pins,
    output sram_wr_t sram_wr,
    output phy_cfg_t phy_cfg,
    output logic irq_drive_type,
    output logic irq_polarity,
    output logic load_done,
    output logic clock_source_test
);

    // ==========================================================
    // Functions
    function automatic phy_cfg_t decode_phy(input logic [2:0] code);
        phy_cfg_t c;
        c = 7'h7C;
        case (code)
            PHY_AN_100: {c.adv_10_full, c.adv_10_half} = 2'h0;
            PHY_AN_10: {c.adv_100_full, c.adv_100_half} = 2'h0;
            PHY_F100_FD: c = 7'h03;
            PHY_F100_HD: c = 7'h02;
            PHY_F10_FD: c = 7'h01;
            PHY_F10_HD: c = 7'h00;
            default: c = c;
        endcase
        return c;
    endfunction

    function automatic sram_wr_t copy_entry(input logic [4:0] idx,
                                            input logic [47:0] mac,
                                            input logic [7:0] fill);
        sram_wr_t w;
        logic [4:0] j;
        logic [7:0] b;
        w.we = 1'b1;
        j = idx - LO_ENTRIES;
        b = mac[{idx[2:0], 3'h0} +: 8];
        if (idx < LO_ENTRIES)
        begin
            w.addr = SRAM_LO_BASE + {10'h000, idx, 1'b0};
            if (idx < MAC_BYTES)
                w.data = {b, b};
            else if (idx >= FILL_FIRST)
                w.data = {fill, fill};
            else
                w.data = 16'h0000;
        end
        else
        begin
            w.addr = SRAM_HI_BASE + {10'h000, j, 1'b0};
            if (j < 5'h03)
                w.data = mac[{j[1:0], 4'h0} +: 16];
            else if (j == HI_FILL)
                w.data = {FILL_SET, FILL_SET};
            else
                w.data = 16'h0000;
        end
        return w;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic hw_reset_n_s;
    logic test_clock_select_s;
    logic test_a_s;
    logic test_b_s;
    logic data_in_s;
    logic hw_reset_n_d;

    pin_sync #(.W(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({hw_reset_n, test_clock_select, test_mode_sel_a,
                   test_mode_sel_b, cfgmem_data_in}),
        .sync_out({hw_reset_n_s, test_clock_select_s, test_a_s, test_b_s,
                   data_in_s})
    );

    // ==========================================================
    // Serial memory engine, shared by loader and host port
    logic eng_start;
    logic [5:0] eng_addr;
    logic eng_busy;
    logic eng_done;
    logic [15:0] eng_rdata;
    logic load_start;
    logic host_start;
    logic [5:0] host_addr;
    logic [5:0] word_idx;

    assign eng_start = load_done ? host_start : load_start;
    assign eng_addr = load_done ? host_addr : word_idx;

    cfgmem_reader u_reader (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(eng_start),
        .word_addr(eng_addr),
        .data_in(data_in_s),
        .busy(eng_busy),
        .done(eng_done),
        .rdata(eng_rdata),
        .pins(cfgmem_pins)
    );

    // ==========================================================
    // Loader state machine
    load_state_t state;
    logic [15:0] word_count;
    logic [15:0] cfg_word [0:5];
    logic [4:0] copy_idx;
    logic sig_valid;
    logic [47:0] mac;
    logic [7:0] fill;

    assign mac = {cfg_word[5], cfg_word[4], cfg_word[3]};
    assign fill = cfg_word[2][FILL_SEL_BIT] ? FILL_SET : FILL_CLR;
    assign load_start = (state == ST_READ);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hw_reset_n_d <= 1'b0;
        else if (ce)
            hw_reset_n_d <= hw_reset_n_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            word_idx <= '0;
            word_count <= '0;
            copy_idx <= '0;
            sig_valid <= 1'b0;
            load_done <= 1'b0;
            for (int i = 0; i < 6; i++)
                cfg_word[i] <= '0;
        end
        else if (ce)
        begin
            if (!hw_reset_n_s)
            begin
                // Held in reset by the pin
                state <= ST_IDLE;
                load_done <= 1'b0;
                sig_valid <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (!hw_reset_n_d)
                        begin
                            word_idx <= WORD_SIG;
                            word_count <= '0;
                            copy_idx <= '0;
                            for (int i = 0; i < 6; i++)
                                cfg_word[i] <= '0;
                            state <= ST_READ;
                        end
                    end
                    ST_READ:
                        if (!eng_busy)
                            state <= ST_WAIT;
                    ST_WAIT:
                    begin
                        if (eng_done)
                        begin
                            if (word_idx <= WORD_LAST)
                                cfg_word[word_idx[2:0]] <= eng_rdata;
                            state <= ST_NEXT;
                        end
                    end
                    ST_NEXT:
                    begin
                        if (word_idx == WORD_SIG)
                        begin
                            if (cfg_word[0] == SIGNATURE)
                            begin
                                sig_valid <= 1'b1;
                                word_idx <= WORD_COUNT;
                                state <= ST_READ;
                            end
                            else
                            begin
                                // Blank memory: nothing copied
                                load_done <= 1'b1;
                                state <= ST_DONE;
                            end
                        end
                        else
                        begin
                            if (word_idx == WORD_COUNT)
                                word_count <= cfg_word[1];
                            word_idx <= word_idx + 6'h01;
                            // Words past the count stay zero
                            if ({10'h000, word_idx} + 16'h0001 >=
                                ((word_idx == WORD_COUNT) ? cfg_word[1] : word_count)
                                || word_idx == 6'h3F)
                                state <= ST_COPY;
                            else
                                state <= ST_READ;
                        end
                    end
                    ST_COPY:
                    begin
                        copy_idx <= copy_idx + 5'h01;
                        if (copy_idx == COPY_LAST)
                            state <= ST_DONE;
                    end
                    ST_DONE:
                        load_done <= 1'b1;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // SRAM port; station address registers REG_MAC_LO and REG_MAC_HI read back loaded words 3-5, not host-writable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sram_wr <= '0;
        else if (ce)
        begin
            if (state == ST_COPY && hw_reset_n_s)
                sram_wr <= copy_entry(copy_idx, mac, fill);
            else
                sram_wr <= '0;
        end
    end

    // PHY mode settles once loading ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phy_cfg <= decode_phy(PHY_AN_ALL);
        else if (ce)
        begin
            if (!sig_valid)
                phy_cfg <= decode_phy(PHY_AN_ALL);
            else if (state == ST_DONE)
                phy_cfg <= decode_phy(cfg_word[2][PHY_FIELD_LSB +: 3]);
        end
    end

    // Clock source select follows the test strap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_source_test <= 1'b0;
        else if (ce)
            clock_source_test <= test_clock_select_s;
    end

    // ==========================================================
    // APB slave
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [7:0] bus_type_control_reg;
    logic bus_type_control_reg_written;
    logic [7:0] bus_type_control_reg_eff;
    logic host_busy;
    logic refused;
    logic [15:0] host_data;
    logic port_cmd;
    logic host_pend_seen;
    logic [5:0] pwdata_addr;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = (paddr <= REG_COUNT) && (paddr[1:0] == 2'h0);
    assign pslverr = psel && penable && !mapped;
    assign port_cmd = wr_en && (paddr == REG_MEM_PORT) && pwdata[PORT_START_BIT];
    assign host_start = host_busy && !eng_busy && port_cmd == 1'b0 && !host_pend_seen;
    assign host_addr = pwdata_addr;

    assign bus_type_control_reg_eff = bus_type_control_reg_written ? bus_type_control_reg :
        bus_type_control_reg | {2'h0, cfg_word[2][IRQ_TYPE_BIT], cfg_word[2][IRQ_POL_BIT], 4'h0};
    assign irq_drive_type = bus_type_control_reg_eff[IRQ_TYPE_BIT];
    assign irq_polarity = bus_type_control_reg_eff[IRQ_POL_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_type_control_reg <= BUS_TYPE_CONTROL_REG_RESET;
            bus_type_control_reg_written <= 1'b0;
        end
        else if (ce)
        begin
            if (!hw_reset_n_s)
                bus_type_control_reg_written <= 1'b0;
            else if (wr_en && paddr == REG_BUS_TYPE)
            begin
                bus_type_control_reg <= pwdata[7:0];
                bus_type_control_reg_written <= 1'b1;
            end
        end
    end

    // Host memory port: one read at a time, refused until load is done
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_busy <= 1'b0;
            host_pend_seen <= 1'b0;
            refused <= 1'b0;
            host_data <= '0;
            pwdata_addr <= '0;
        end
        else if (ce)
        begin
            if (port_cmd && (!load_done || host_busy))
                refused <= 1'b1;
            else if (port_cmd)
            begin
                refused <= 1'b0;
                host_busy <= 1'b1;
                host_pend_seen <= 1'b0;
                pwdata_addr <= pwdata[5:0];
            end
            else if (host_busy)
            begin
                if (host_start)
                    host_pend_seen <= 1'b1;
                if (host_pend_seen && eng_done)
                begin
                    host_data <= eng_rdata;
                    host_busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (ce && rd_setup)
        begin
            case (paddr)
                REG_STATUS: prdata <= {21'h0, test_b_s, test_a_s, test_clock_select_s,
                                       1'b0, cfg_word[2][PHY_FIELD_LSB +: 3],
                                       1'b0, !load_done, sig_valid, load_done};
                REG_PHY: prdata <= {25'h0, phy_cfg};
                REG_MAC_LO: prdata <= {cfg_word[4], cfg_word[3]};
                REG_MAC_HI: prdata <= {16'h0, cfg_word[5]};
                REG_BUS_TYPE: prdata <= {24'h0, bus_type_control_reg_eff};
                REG_MEM_PORT: prdata <= {host_busy, refused, 14'h0, host_data};
                REG_COUNT: prdata <= {16'h0, word_count};
                default: prdata <= '0;
            endcase
        end
    end

endmodule // cfg_autoloader
`default_nettype wire

// File: verification/cfg_autoloader_sva.sv
// Checker: concurrent properties on the loader top ports.
// Bound from the bench top; one pclk domain.
`timescale 1ns/10ps
`default_nettype none
module cfg_autoloader_sva
    import cfg_loader_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hw_reset_n,
    input wire logic test_clock_select,
    input wire sram_wr_t sram_wr,
    input wire phy_cfg_t phy_cfg,
    input wire logic load_done,
    input wire logic clock_source_test
);
    // ==========
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    idle_reset_a: assert property (!hw_reset_n [*5] |-> !load_done)
        else $error("load_done high in hardware reset");
    gate_done_a: assert property (sram_wr.we |-> !load_done)
        else $error("sram write after load_done");
    sram_region_a: assert property (sram_wr.we |-> sram_wr.addr < 16'h0020 ||
        sram_wr.addr[15:4] == 12'h040) else $error("sram write outside regions");
    fill_value_a: assert property (sram_wr.we && sram_wr.addr[15:2] == 14'h0007 |->
        sram_wr.data inside {16'h5757, 16'h4242}) else $error("bad fill value");
    done_rise_a: assert property ($rose(load_done) |-> $past(sram_wr.we) ||
        phy_cfg == 7'h7C) else $error("blank memory without default phy");
    phy_legal_a: assert property (load_done |-> phy_cfg inside
        {7'h7C, 7'h70, 7'h4C, 7'h03, 7'h02, 7'h01, 7'h00}) else $error("bad phy_cfg");
    phy_stable_a: assert property (load_done && $past(load_done) |-> $stable(phy_cfg))
        else $error("phy_cfg moved after load");
    clk_sel_a: assert property (test_clock_select [*4] |-> clock_source_test)
        else $error("test clock not selected");
    cover property ($rose(load_done));
    cover property (sram_wr.we && sram_wr.addr == 16'h040E);
    cover property (clock_source_test);
endmodule // cfg_autoloader_sva
`default_nettype wire

// File: verification/cfgmem_model.sv
// Serial configuration memory model: 64 words, 9-bit read command.
// Driven by the loader pins; word contents set by the bench.
`timescale 1ns/10ps
`default_nettype none
module cfgmem_model
    import cfg_loader_pkg::*;
(
    input wire logic pclk,
    input wire cfgmem_pins_t pins,
    output logic data_in
);
    // ==========
    // Frame engine
    logic [15:0] mem [64];
    logic [15:0] sh;
    logic [7:0] cmd;
    logic ck_d;
    int n;
    initial data_in = 1'b1;
    always @(posedge pclk)
    begin
        ck_d <= pins.clock;
        if (!pins.select)
        begin
            n <= 0;
            data_in <= 1'b1; // Pull-up level once released
        end
        else if (pins.clock && !ck_d)
        begin
            n <= n + 1;
            cmd <= {cmd[6:0], pins.data_out};
            if (n == 8)
                sh <= mem[{cmd[4:0], pins.data_out}];
        end
        else if (!pins.clock && ck_d)
        begin
            // Change on falling clock; toggle when no bit is due
            data_in <= (n > 8 && n < 25) ? sh[15] : ~data_in;
            sh <= {sh[14:0], 1'b0};
        end
    end
endmodule // cfgmem_model
`default_nettype wire

// File: verification/test_cfg_autoloader.sv
// Bench: loads, phy codes, blank memory, host port, test clock.
// Assumes the memory model and the checker beside the loader.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_cfg_autoloader;
    import cfg_loader_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic hw_reset_n = 0, test_clock_select = 0, pready, pslverr, cfgmem_data_in;
    logic irq_drive_type, irq_polarity, load_done, clock_source_test;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    cfgmem_pins_t cfgmem_pins;
    sram_wr_t sram_wr;
    phy_cfg_t phy_cfg;
    logic [15:0] sram [logic [15:0]];
    int failures = 0, checks = 0, nwr = 0;
    localparam logic [6:0] PX [8] = '{7'h7C, 7'h70, 7'h4C, 7'h7C, 7'h03, 7'h02, 7'h01, 7'h00};
    cfg_autoloader u_cfg_autoloader (.pclk, .presetn, .ce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_reset_n,
        .test_clock_select, .test_mode_sel_a(1'b0), .test_mode_sel_b(1'b0),
        .cfgmem_data_in, .cfgmem_pins, .sram_wr, .phy_cfg, .irq_drive_type,
        .irq_polarity, .load_done, .clock_source_test);
    cfgmem_model u_cfgmem_model (.pclk, .pins(cfgmem_pins), .data_in(cfgmem_data_in));
    // ==========
    // Bus and load tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic go(input logic [15:0] w2, input logic [15:0] sig);
        u_cfgmem_model.mem[0] = sig; u_cfgmem_model.mem[2] = w2;
        sram.delete(); nwr = 0;
        @(posedge pclk) hw_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        hw_reset_n <= 1'b1;
    endtask
    task automatic wait_done();
        while (load_done !== 1'b1) @(posedge pclk);
    endtask
    always @(posedge pclk) if (sram_wr.we === 1'b1) begin sram[sram_wr.addr] = sram_wr.data;
        nwr++; end
    // ==========
    // Scenarios
    task automatic t_valid();
        logic [47:0] mac = 48'hBA9876543210;
        go(16'h0434, 16'h5AA5); wait_done();
        for (int i = 0; i < 6; i++) `CHK(sram[16'(2*i)], {2{mac[8*i +: 8]}})
        `CHK(sram[16'h0010], 16'h0000) `CHK(sram[16'h001C], 16'h5757)
        `CHK(sram[16'h0400], 16'h3210) `CHK(sram[16'h0404], 16'hBA98)
        `CHK(sram[16'h040E], 16'h5757) `CHK(nwr, 24) `CHK(phy_cfg, 7'h03)
        `CHK({irq_drive_type, irq_polarity}, 2'b11)
        apb(0, 8'h10, 0); `CHK(rd[5:4], 2'b11)
        apb(1, 8'h10, 0); apb(0, 8'h10, 0); `CHK(rd[7:0], 8'h00)
        apb(0, 8'h18, 0); `CHK(rd[15:0], 16'h0006)
        apb(0, 8'h1C, 0); `CHK(er, 1'b1)
        $display("test valid load done");
    endtask
    task automatic t_codes();
        for (int c = 0; c < 8; c++)
        begin
            go({5'h1F, 3'(c), 8'h00}, 16'h5AA5); wait_done();
            `CHK(phy_cfg, PX[c]) `CHK(sram[16'h001E], 16'h4242)
        end
        go(16'h0000, 16'h1234); wait_done();
        `CHK(nwr, 0) `CHK(phy_cfg, 7'h7C)
        apb(0, 8'h00, 0); `CHK(rd[1:0], 2'b01)
        $display("test codes done");
    endtask
    task automatic t_port();
        go(16'h0000, 16'h5AA5);
        apb(1, 8'h14, 32'h80000004); apb(0, 8'h14, 0); `CHK(rd[30], 1'b1)
        wait_done(); apb(1, 8'h14, 32'h80000004);
        for (int n = 0; n < 400 && (n == 0 || rd[31] !== 1'b0); n++) apb(0, 8'h14, 0);
        `CHK(rd[31:30], 2'b00) `CHK(rd[15:0], 16'h7654)
        test_clock_select <= 1'b1; repeat (6) @(posedge pclk);
        `CHK(clock_source_test, 1'b1) test_clock_select <= 1'b0;
        $display("test port done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial forever #50 pclk = ~pclk;
    initial
    begin
        u_cfgmem_model.mem[1] = 16'h0006; u_cfgmem_model.mem[3] = 16'h3210;
        u_cfgmem_model.mem[4] = 16'h7654; u_cfgmem_model.mem[5] = 16'hBA98;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_valid(); t_codes(); t_port(); tally_and_finish();
    end
    initial
    begin
        repeat (40000) @(posedge pclk);
        failures++; tally_and_finish();
    end
endmodule // test_cfg_autoloader
bind cfg_autoloader cfg_autoloader_sva u_sva (.pclk, .presetn, .hw_reset_n,
    .test_clock_select, .sram_wr, .phy_cfg, .load_done, .clock_source_test);
`default_nettype wire
